// file: inc/pstc_pkg.sv
// Constants and carrier types for the port state and trunk control block.
// Assumes a single system clock and a synchronous register port master.
//
// Summary of operation
// - A port whose link is down is held in the disabled state.
// - Blocking: no forwarding and no address learning on the port.
// - Listening: no forwarding and no address learning on the port.
// - Learning: learn source addresses but do not forward traffic.
// - Forwarding: forward traffic and learn source addresses.
// - After boot reset every port starts in blocking.
// - Blocking may move only to listening or disabled.
// - Listening may move only to learning or disabled.
// - Learning may move only to forwarding or disabled.
// - Forwarding may leave only to disabled.
// - Disabled may leave only to blocking.
// - Port state gates forwarding only when spanning tree is enabled on the port.
// - Blocking is reported only while the classic protocol variant is selected.
// - At most eight static trunk groups exist in the system.
// - Members per group limited to 8 on small variant, 12 on large.
// - A port belongs to at most one trunk group at a time.
// - A port set as normal is in no trunk group.
// - Group members must share one speed and run full duplex.
// - A group is treated as one logical port with speed and duplex.
// - Each port reports an edge-port flag and a point-to-point flag.
// - On loops, lower path cost ports are preferred to stay unblocked; here the path cost is only stored per port and read back.
package pstc_pkg;

	localparam int NUM_PORTS = 24;
	localparam int NUM_GROUPS = 8;
	localparam int GROUP_LIMIT_SMALL = 8;
	localparam int GROUP_LIMIT_LARGE = 12;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int COST_W = 24;

	// Register indices, one 32-bit word each
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_PORT_SEL = 8'h04;
	localparam logic [ADDR_W-1:0] REG_PORT_CFG = 8'h08;
	localparam logic [ADDR_W-1:0] REG_STATE_REQ = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_PORT_STAT = 8'h10;
	localparam logic [ADDR_W-1:0] REG_PATH_COST = 8'h14;
	localparam logic [ADDR_W-1:0] REG_GROUP_STAT = 8'h18;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

	// CTRL fields
	localparam int CTRL_CLASSIC_BIT = 0;
	localparam int CTRL_LARGE_BIT = 1;
	// PORT_CFG fields
	localparam int CFG_STP_EN_BIT = 0;
	localparam int CFG_EDGE_BIT = 1;
	localparam int CFG_P2P_BIT = 2;
	localparam int CFG_TRUNK_EN_BIT = 3;
	localparam int CFG_GROUP_LSB = 4;
	localparam int GROUP_W = 3;
	// PORT_STAT fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_FWD_BIT = 4;
	localparam int STAT_LEARN_BIT = 5;
	localparam int STAT_LINK_BIT = 6;
	localparam int STAT_REJ_BIT = 7;
	localparam int STAT_CFG_REJ_BIT = 8;
	localparam int STAT_MEMBER_BIT = 9;
	localparam int STAT_SPEED_LSB = 12;
	localparam int SPEED_W = 2;
	localparam int STAT_FDX_BIT = 14;

	localparam logic [2:0] ST_DISABLED = 3'h0;
	localparam logic [2:0] ST_BLOCKING = 3'h1;
	localparam logic [2:0] ST_LISTENING = 3'h2;
	localparam logic [2:0] ST_LEARNING = 3'h3;
	localparam logic [2:0] ST_FORWARDING = 3'h4;
	// Reported when classic blocking is hidden
	localparam logic [2:0] ST_DISCARDING = 3'h5;

	typedef enum logic [4:0] {
		S_DISABLED = 5'h01,
		S_BLOCKING = 5'h02,
		S_LISTENING = 5'h04,
		S_LEARNING = 5'h08,
		S_FORWARDING = 5'h10
	} port_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic link_up;
		logic full_duplex;
		logic [SPEED_W-1:0] speed;
	} link_info_t;

endpackage : pstc_pkg

// file: rtl/port_state_fsm.sv
// One port's spanning-tree state machine with forward/learn gating.
// Assumes link status and requests are synchronous to i_mclk.
`timescale 1ns/1ps
module port_state_fsm (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_link_up,
	input wire logic i_stp_en,
	input wire logic i_req_valid,
	input wire logic [2:0] i_req_state,
	output logic [2:0] o_state_code,
	output logic o_forward,
	output logic o_learn,
	output logic o_reject
);
	pstc_pkg::port_state_t state_q, state_d;
	logic reject_d;
	logic reject_q;

	function automatic logic [2:0] encode(input pstc_pkg::port_state_t s);
		unique case (s)
			pstc_pkg::S_DISABLED: encode = pstc_pkg::ST_DISABLED;
			pstc_pkg::S_BLOCKING: encode = pstc_pkg::ST_BLOCKING;
			pstc_pkg::S_LISTENING: encode = pstc_pkg::ST_LISTENING;
			pstc_pkg::S_LEARNING: encode = pstc_pkg::ST_LEARNING;
			pstc_pkg::S_FORWARDING: encode = pstc_pkg::ST_FORWARDING;
			default: encode = pstc_pkg::ST_DISABLED;
		endcase
	endfunction : encode

	always_comb begin
		state_d = state_q;
		reject_d = 1'b0;
		if (!i_link_up) begin
			state_d = pstc_pkg::S_DISABLED;
			reject_d = i_req_valid && (i_req_state != pstc_pkg::ST_DISABLED);
		end else if (i_req_valid) begin
			reject_d = 1'b1;
			unique case (state_q)
				pstc_pkg::S_BLOCKING: begin
					if (i_req_state == pstc_pkg::ST_LISTENING) begin
						state_d = pstc_pkg::S_LISTENING;
						reject_d = 1'b0;
					end
				end
				pstc_pkg::S_LISTENING: begin
					if (i_req_state == pstc_pkg::ST_LEARNING) begin
						state_d = pstc_pkg::S_LEARNING;
						reject_d = 1'b0;
					end
				end
				pstc_pkg::S_LEARNING: begin
					if (i_req_state == pstc_pkg::ST_FORWARDING) begin
						state_d = pstc_pkg::S_FORWARDING;
						reject_d = 1'b0;
					end
				end
				pstc_pkg::S_FORWARDING: begin
					reject_d = 1'b1;
				end
				pstc_pkg::S_DISABLED: begin
					if (i_req_state == pstc_pkg::ST_BLOCKING) begin
						state_d = pstc_pkg::S_BLOCKING;
						reject_d = 1'b0;
					end
				end
			endcase
			// Any state may fall to disabled on request
			if (i_req_state == pstc_pkg::ST_DISABLED && state_q != pstc_pkg::S_DISABLED) begin
				state_d = pstc_pkg::S_DISABLED;
				reject_d = 1'b0;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= pstc_pkg::S_BLOCKING;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			reject_q <= 1'b0;
		end else begin
			reject_q <= reject_d;
		end
	end

	// Spanning tree off: traffic passes regardless of state
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_forward <= 1'b0;
			o_learn <= 1'b0;
		end else begin
			o_forward <= i_link_up && (!i_stp_en || state_d == pstc_pkg::S_FORWARDING);
			o_learn <= i_link_up && (!i_stp_en || state_d == pstc_pkg::S_FORWARDING
				|| state_d == pstc_pkg::S_LEARNING);
		end
	end

	assign o_state_code = encode(state_q);
	assign o_reject = reject_q;

endmodule : port_state_fsm

// file: rtl/port_state_trunk_ctrl.sv
// Per-port state machines, trunk membership and the register port.
// Assumes a master that keeps strobes one cycle wide and never both at once.
`timescale 1ns/1ps
module port_state_trunk_ctrl #(
	parameter int NUM_PORTS = pstc_pkg::NUM_PORTS,
	parameter int NUM_GROUPS = pstc_pkg::NUM_GROUPS
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [pstc_pkg::ADDR_W-1:0] i_addr,
	input wire logic [pstc_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [NUM_PORTS-1:0] i_link_up,
	input wire logic [NUM_PORTS-1:0] i_full_duplex,
	input wire logic [NUM_PORTS*pstc_pkg::SPEED_W-1:0] i_speed,
	output logic [pstc_pkg::DATA_W-1:0] o_rdata,
	output logic [NUM_PORTS-1:0] o_forward,
	output logic [NUM_PORTS-1:0] o_learn,
	output logic [NUM_PORTS-1:0] o_edge_port,
	output logic [NUM_PORTS-1:0] o_point_to_point_flag,
	output logic [NUM_PORTS-1:0] o_trunk_member,
	output logic [NUM_PORTS*pstc_pkg::GROUP_W-1:0] o_group_id
);
	localparam int PSEL_W = $clog2(NUM_PORTS);
	localparam int CNT_W = $clog2(NUM_PORTS + 1);

	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta_q;
	logic rst_n_q;
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// ****************************************
	// Register decode
	// ****************************************
	pstc_pkg::reg_req_t req;
	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	function automatic logic hit(input pstc_pkg::reg_req_t r, input logic [pstc_pkg::ADDR_W-1:0] a);
		hit = (r.addr == a);
	endfunction : hit

	logic classic_q;
	logic large_q;
	logic [PSEL_W-1:0] psel_q;
	logic [NUM_PORTS-1:0] stp_en_q;
	logic [NUM_PORTS-1:0] edge_q;
	logic [NUM_PORTS-1:0] p2p_q;
	logic [NUM_PORTS-1:0] trunk_en_q;
	logic [pstc_pkg::GROUP_W-1:0] grp_q [NUM_PORTS];
	logic [pstc_pkg::COST_W-1:0] cost_q [NUM_PORTS];
	logic [NUM_PORTS-1:0] cfg_rej_q;

	logic psel_ok;
	assign psel_ok = (32'(psel_q) < NUM_PORTS);

	always_ff @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			classic_q <= 1'b1;
			large_q <= 1'b1;
		end else if (req.wr && hit(req, pstc_pkg::REG_CTRL)) begin
			classic_q <= req.wdata[pstc_pkg::CTRL_CLASSIC_BIT];
			large_q <= req.wdata[pstc_pkg::CTRL_LARGE_BIT];
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			psel_q <= '0;
		end else if (req.wr && hit(req, pstc_pkg::REG_PORT_SEL)) begin
			psel_q <= req.wdata[PSEL_W-1:0];
		end
	end

	// ****************************************
	// Trunk membership check
	// ****************************************
	logic [pstc_pkg::GROUP_W-1:0] new_grp;
	logic new_trunk;
	logic [CNT_W-1:0] members;
	logic [CNT_W-1:0] limit;
	logic ref_found;
	logic [pstc_pkg::SPEED_W-1:0] ref_speed;
	logic cfg_ok;

	assign new_grp = req.wdata[pstc_pkg::CFG_GROUP_LSB +: pstc_pkg::GROUP_W];
	assign new_trunk = req.wdata[pstc_pkg::CFG_TRUNK_EN_BIT];
	assign limit = large_q ? CNT_W'(pstc_pkg::GROUP_LIMIT_LARGE)
		: CNT_W'(pstc_pkg::GROUP_LIMIT_SMALL);

	always_comb begin
		members = '0;
		ref_found = 1'b0;
		ref_speed = '0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (trunk_en_q[p] && grp_q[p] == new_grp && 32'(psel_q) != p) begin
				members = members + CNT_W'(1);
				if (!ref_found) begin
					ref_found = 1'b1;
					ref_speed = i_speed[p*pstc_pkg::SPEED_W +: pstc_pkg::SPEED_W];
				end
			end
		end
	end

	// Checked at join time only; a later speed change is left to software
	always_comb begin
		cfg_ok = 1'b1;
		if (new_trunk) begin
			if (members >= limit) begin
				cfg_ok = 1'b0;
			end
			if (!i_full_duplex[psel_q]) begin
				cfg_ok = 1'b0;
			end
			if (ref_found && ref_speed != i_speed[psel_q*pstc_pkg::SPEED_W +: pstc_pkg::SPEED_W]) begin
				cfg_ok = 1'b0;
			end
		end
	end

	logic cfg_wr;
	assign cfg_wr = req.wr && hit(req, pstc_pkg::REG_PORT_CFG) && psel_ok;

	// ****************************************
	// Per-port state and configuration
	// ****************************************
	logic [2:0] state_code [NUM_PORTS];
	logic [NUM_PORTS-1:0] rejected;

	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++) begin : g_port
			logic req_v;
			assign req_v = req.wr && hit(req, pstc_pkg::REG_STATE_REQ) && 32'(psel_q) == g;

			always_ff @(posedge i_mclk or negedge rst_n_q) begin
				if (!rst_n_q) begin
					stp_en_q[g] <= 1'b1;
					edge_q[g] <= 1'b0;
					p2p_q[g] <= 1'b0;
				end else if (cfg_wr && 32'(psel_q) == g) begin
					stp_en_q[g] <= req.wdata[pstc_pkg::CFG_STP_EN_BIT];
					edge_q[g] <= req.wdata[pstc_pkg::CFG_EDGE_BIT];
					p2p_q[g] <= req.wdata[pstc_pkg::CFG_P2P_BIT];
				end
			end

			// Single group field per port: one group at most
			always_ff @(posedge i_mclk or negedge rst_n_q) begin
				if (!rst_n_q) begin
					trunk_en_q[g] <= 1'b0;
					grp_q[g] <= '0;
					cfg_rej_q[g] <= 1'b0;
				end else if (cfg_wr && 32'(psel_q) == g) begin
					cfg_rej_q[g] <= !cfg_ok;
					if (!new_trunk) begin
						trunk_en_q[g] <= 1'b0;
					end else if (cfg_ok) begin
						trunk_en_q[g] <= 1'b1;
						grp_q[g] <= new_grp;
					end
				end
			end

			always_ff @(posedge i_mclk or negedge rst_n_q) begin
				if (!rst_n_q) begin
					cost_q[g] <= '0;
				end else if (req.wr && hit(req, pstc_pkg::REG_PATH_COST) && 32'(psel_q) == g) begin
					cost_q[g] <= req.wdata[pstc_pkg::COST_W-1:0];
				end
			end

			port_state_fsm u_fsm (
				.i_mclk(i_mclk),
				.i_rst_n(rst_n_q),
				.i_link_up(i_link_up[g]),
				.i_stp_en(stp_en_q[g]),
				.i_req_valid(req_v),
				.i_req_state(req.wdata[2:0]),
				.o_state_code(state_code[g]),
				.o_forward(o_forward[g]),
				.o_learn(o_learn[g]),
				.o_reject(rejected[g])
			);

			assign o_edge_port[g] = edge_q[g];
			assign o_point_to_point_flag[g] = p2p_q[g];
			assign o_trunk_member[g] = trunk_en_q[g];
			assign o_group_id[g*pstc_pkg::GROUP_W +: pstc_pkg::GROUP_W] = grp_q[g];
		end
	endgenerate

	// ****************************************
	// Group logical port view
	// ****************************************
	logic [NUM_GROUPS-1:0] grp_up;
	logic [NUM_GROUPS-1:0] grp_fdx;
	logic [pstc_pkg::SPEED_W-1:0] grp_speed [NUM_GROUPS];
	always_comb begin
		grp_up = '0;
		grp_fdx = '0;
		for (int k = 0; k < NUM_GROUPS; k++) begin
			grp_speed[k] = '0;
		end
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (trunk_en_q[p] && i_link_up[p]) begin
				grp_up[grp_q[p]] = 1'b1;
				grp_fdx[grp_q[p]] = i_full_duplex[p];
				grp_speed[grp_q[p]] = i_speed[p*pstc_pkg::SPEED_W +: pstc_pkg::SPEED_W];
			end
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	logic [2:0] shown_state;
	// Hiding blocking keeps rapid-mode reports free of the classic term
	assign shown_state = (state_code[psel_q] == pstc_pkg::ST_BLOCKING && !classic_q)
		? pstc_pkg::ST_DISCARDING : state_code[psel_q];

	logic [pstc_pkg::DATA_W-1:0] rdata_d;
	always_comb begin
		rdata_d = pstc_pkg::UNMAPPED_READ;
		if (hit(req, pstc_pkg::REG_CTRL)) begin
			rdata_d[pstc_pkg::CTRL_CLASSIC_BIT] = classic_q;
			rdata_d[pstc_pkg::CTRL_LARGE_BIT] = large_q;
		end else if (hit(req, pstc_pkg::REG_PORT_SEL)) begin
			rdata_d[PSEL_W-1:0] = psel_q;
		end else if (hit(req, pstc_pkg::REG_PORT_CFG) && psel_ok) begin
			rdata_d[pstc_pkg::CFG_STP_EN_BIT] = stp_en_q[psel_q];
			rdata_d[pstc_pkg::CFG_EDGE_BIT] = edge_q[psel_q];
			rdata_d[pstc_pkg::CFG_P2P_BIT] = p2p_q[psel_q];
			rdata_d[pstc_pkg::CFG_TRUNK_EN_BIT] = trunk_en_q[psel_q];
			rdata_d[pstc_pkg::CFG_GROUP_LSB +: pstc_pkg::GROUP_W] = grp_q[psel_q];
		end else if (hit(req, pstc_pkg::REG_PORT_STAT) && psel_ok) begin
			rdata_d[pstc_pkg::STAT_STATE_LSB +: 3] = shown_state;
			rdata_d[pstc_pkg::STAT_FWD_BIT] = o_forward[psel_q];
			rdata_d[pstc_pkg::STAT_LEARN_BIT] = o_learn[psel_q];
			rdata_d[pstc_pkg::STAT_LINK_BIT] = i_link_up[psel_q];
			rdata_d[pstc_pkg::STAT_REJ_BIT] = rejected[psel_q];
			rdata_d[pstc_pkg::STAT_CFG_REJ_BIT] = cfg_rej_q[psel_q];
			rdata_d[pstc_pkg::STAT_MEMBER_BIT] = trunk_en_q[psel_q];
		end else if (hit(req, pstc_pkg::REG_PATH_COST) && psel_ok) begin
			rdata_d[pstc_pkg::COST_W-1:0] = cost_q[psel_q];
		end else if (hit(req, pstc_pkg::REG_GROUP_STAT)) begin
			// Port select low bits pick the group
			rdata_d[pstc_pkg::STAT_LINK_BIT] = grp_up[psel_q[pstc_pkg::GROUP_W-1:0]];
			rdata_d[pstc_pkg::STAT_SPEED_LSB +: pstc_pkg::SPEED_W] =
				grp_speed[psel_q[pstc_pkg::GROUP_W-1:0]];
			rdata_d[pstc_pkg::STAT_FDX_BIT] = grp_fdx[psel_q[pstc_pkg::GROUP_W-1:0]];
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_rdata <= '0;
		end else if (req.rd) begin
			o_rdata <= rdata_d;
		end else begin
			o_rdata <= '0;
		end
	end

endmodule : port_state_trunk_ctrl

// file: tb/link_partner_model.sv
// Far-end switch ports: link comes up after a settle delay, drops at once.
// Assumes the bench sets the wanted link, duplex and speed per port.
`timescale 1ns/1ps
module link_partner_model #(
	parameter int NUM_PORTS = 24,
	parameter int UP_DELAY = 6
) (
	input wire logic i_mclk,
	input wire logic [NUM_PORTS-1:0] i_want_up,
	input wire logic [NUM_PORTS-1:0] i_want_fdx,
	input wire logic [2*NUM_PORTS-1:0] i_want_speed,
	output logic [NUM_PORTS-1:0] o_link_up,
	output logic [NUM_PORTS-1:0] o_full_duplex,
	output logic [2*NUM_PORTS-1:0] o_speed
);
	int cnt [NUM_PORTS];
	initial begin
		foreach (cnt[i]) cnt[i] = UP_DELAY;
	end
	always @(posedge i_mclk) begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (!i_want_up[i])
				cnt[i] <= 0;
			else if (cnt[i] < UP_DELAY)
				cnt[i] <= cnt[i] + 1;
		end
	end
	// Dead link: duplex and speed carry no meaning, show the inverse
	always_comb begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			o_link_up[i] = (cnt[i] == UP_DELAY);
			o_full_duplex[i] = o_link_up[i] ? i_want_fdx[i] : ~i_want_fdx[i];
			o_speed[2*i +: 2] = o_link_up[i] ? i_want_speed[2*i +: 2] : ~i_want_speed[2*i +: 2];
		end
	end
endmodule : link_partner_model

// file: tb/port_state_trunk_ctrl_monitor.sv
// Checker for the port state and trunk block, bound to its top module.
// Assumes one clock domain and a bus master that keeps strobes one cycle wide.
`timescale 1ns/1ps
module port_state_trunk_ctrl_monitor #(
	parameter int NUM_PORTS = 24,
	parameter int NUM_GROUPS = 8
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [NUM_PORTS-1:0] i_link_up,
	input wire logic [pstc_pkg::DATA_W-1:0] o_rdata,
	input wire logic [NUM_PORTS-1:0] o_forward,
	input wire logic [NUM_PORTS-1:0] o_learn,
	input wire logic [NUM_PORTS-1:0] o_edge_port,
	input wire logic [NUM_PORTS-1:0] o_point_to_point_flag,
	input wire logic [NUM_PORTS-1:0] o_trunk_member,
	input wire logic [NUM_PORTS*pstc_pkg::GROUP_W-1:0] o_group_id
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	sequence s_no_wr;
		!i_wr [*3];
	endsequence
	// Link must settle too, it forces the state
	sequence s_quiet;
		(!i_wr && $stable(i_link_up)) [*3];
	endsequence
	property p_link_down;
		((~i_link_up & ~$past(i_link_up) & ~$past(i_link_up, 2)) & (o_forward | o_learn)) == '0;
	endproperty
	property p_fwd_learn;
		(o_forward & ~o_learn) == '0;
	endproperty
	property p_boot;
		$rose(i_rstn) |-> (o_forward == '0 && o_learn == '0) [*4];
	endproperty
	property p_hold;
		s_quiet |=> $stable(o_forward) && $stable(o_learn);
	endproperty
	property p_trunk_hold;
		s_no_wr |=> $stable(o_trunk_member) && $stable(o_group_id);
	endproperty
	property p_member_cause;
		$changed(o_trunk_member) |-> $past(i_wr) || $past(i_wr, 2);
	endproperty
	property p_flags_hold;
		s_no_wr |=> $stable(o_edge_port) && $stable(o_point_to_point_flag);
	endproperty
	property p_rdata_idle;
		!$past(i_rd) |-> o_rdata == '0;
	endproperty
	a_link_down: assert property (p_link_down)
		else $error("port with link down may still forward or learn");
	a_fwd_learn: assert property (p_fwd_learn)
		else $error("port forwards without learning");
	a_boot: assert property (p_boot)
		else $error("port active right after boot");
	a_hold: assert property (p_hold)
		else $error("forward or learn changed with no request");
	a_trunk_hold: assert property (p_trunk_hold)
		else $error("trunk membership changed with no write");
	a_member_cause: assert property (p_member_cause)
		else $error("trunk member flag moved without a write");
	a_flags_hold: assert property (p_flags_hold)
		else $error("edge or point to point flag changed with no write");
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero outside a read answer");
endmodule : port_state_trunk_ctrl_monitor

bind port_state_trunk_ctrl port_state_trunk_ctrl_monitor #(
	.NUM_PORTS(NUM_PORTS),
	.NUM_GROUPS(NUM_GROUPS)
) u_monitor (
	.i_mclk(i_mclk),
	.i_rstn(i_rstn),
	.i_wr(i_wr),
	.i_rd(i_rd),
	.i_link_up(i_link_up),
	.o_rdata(o_rdata),
	.o_forward(o_forward),
	.o_learn(o_learn),
	.o_edge_port(o_edge_port),
	.o_point_to_point_flag(o_point_to_point_flag),
	.o_trunk_member(o_trunk_member),
	.o_group_id(o_group_id)
);

// file: tb/port_state_trunk_ctrl_tb.sv
// Self-checking bench for the port state and trunk block.
// Assumes the checker is bound in and the partner model drives the link pins.
`timescale 1ns/1ps
module port_state_trunk_ctrl_tb;
	logic i_mclk, i_rstn, i_wr, i_rd;
	logic [7:0] i_addr;
	logic [31:0] i_wdata, o_rdata, rv;
	logic [23:0] want_up, want_fdx, link_up, fdx, o_fwd, o_lrn, o_edge, o_p2p, o_mem;
	logic [47:0] want_speed, speed;
	logic [71:0] o_gid;
	int n_errors, total_checks, cycles;
	logic [8:0] walk [12] = '{9'h090, 9'h114, 9'h0d9, 9'h05d, 9'h123, 9'h0e7,
		9'h000, 9'h084, 9'h048, 9'h090, 9'h0d9, 9'h123};

	port_state_trunk_ctrl u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_link_up(link_up),
		.i_full_duplex(fdx), .i_speed(speed), .o_rdata(o_rdata), .o_forward(o_fwd),
		.o_learn(o_lrn), .o_edge_port(o_edge), .o_point_to_point_flag(o_p2p),
		.o_trunk_member(o_mem), .o_group_id(o_gid));
	link_partner_model u_partner (.i_mclk(i_mclk), .i_want_up(want_up), .i_want_fdx(want_fdx),
		.i_want_speed(want_speed), .o_link_up(link_up), .o_full_duplex(fdx), .o_speed(speed));

	// ****************************************
	// Clock, timeout and shared tasks
	// ****************************************
	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			print_verdict();
		end
	end
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask : chk
	// Tasks start and end in the time step of a rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		@(posedge i_mclk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		@(negedge i_mclk);
		rv = o_rdata;
		@(posedge i_mclk);
	endtask : rd
	// Status read follows the request with no gap, the refusal flag is short lived
	task automatic req(input logic [2:0] s);
		i_addr <= pstc_pkg::REG_STATE_REQ;
		i_wdata <= {29'h0, s};
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		rd(pstc_pkg::REG_PORT_STAT);
	endtask : req
	task automatic join_grp(input logic [4:0] p, input logic [2:0] g);
		wr(pstc_pkg::REG_PORT_SEL, {27'h0, p});
		wr(pstc_pkg::REG_PORT_CFG, {25'h0, g, 4'h9});
		rd(pstc_pkg::REG_PORT_STAT);
	endtask : join_grp
	task automatic wait_link(input logic v);
		for (int k = 0; k < 20 && link_up[0] !== v; k++) @(posedge i_mclk);
	endtask : wait_link

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_boot;
		rd(pstc_pkg::REG_CTRL);
		chk("ctrl reset", rv, 32'h3);
		rd(8'h1c);
		chk("unmapped read", rv, 32'h0);
		wr(pstc_pkg::REG_PORT_SEL, 32'h0);
		rd(pstc_pkg::REG_PORT_STAT);
		chk("boot state", rv & 32'h7, 32'(pstc_pkg::ST_BLOCKING));
		chk("boot gates", {8'h0, o_fwd | o_lrn}, 32'h0);
		$display("done boot");
	endtask : t_boot
	task automatic t_walk;
		foreach (walk[i]) begin
			req(walk[i][8:6]);
			chk("walk stat", {26'h0, rv[2:0], rv[7], rv[4], rv[5]}, {26'h0, walk[i][5:0]});
			chk("walk pins", {30'h0, o_fwd[0], o_lrn[0]}, {30'h0, walk[i][1:0]});
		end
		$display("done walk");
	endtask : t_walk
	task automatic t_link;
		want_up[0] <= 1'b0;
		wait_link(1'b0);
		rd(pstc_pkg::REG_PORT_STAT);
		chk("down stat", rv & 32'h77, 32'h0);
		want_up[0] <= 1'b1;
		wait_link(1'b1);
		req(3'h2);
		chk("up stays off", rv & 32'h87, 32'h80);
		req(3'h1);
		chk("back blocking", rv & 32'hc7, 32'h41);
		$display("done link");
	endtask : t_link
	task automatic t_cfg;
		wr(pstc_pkg::REG_CTRL, 32'h2);
		rd(pstc_pkg::REG_PORT_STAT);
		chk("modern state", rv & 32'h7, 32'(pstc_pkg::ST_DISCARDING));
		wr(pstc_pkg::REG_CTRL, 32'h3);
		wr(pstc_pkg::REG_PORT_CFG, 32'h6);
		// Gates follow the enable one edge late; let that edge settle first
		@(posedge i_mclk);
		chk("stp off", {28'h0, o_fwd[0], o_lrn[0], o_edge[0], o_p2p[0]}, 32'hf);
		wr(pstc_pkg::REG_PORT_CFG, 32'h1);
		@(posedge i_mclk);
		chk("stp on", {28'h0, o_fwd[0], o_lrn[0], o_edge[0], o_p2p[0]}, 32'h0);
		wr(pstc_pkg::REG_PATH_COST, 32'hffab_cdef);
		rd(pstc_pkg::REG_PATH_COST);
		chk("path cost", rv, 32'h00ab_cdef);
		$display("done cfg");
	endtask : t_cfg
	task automatic t_trunk;
		wr(pstc_pkg::REG_CTRL, 32'h1);
		for (int p = 0; p < 9; p++) begin
			join_grp(5'(p), 3'h3);
			chk("small join", rv & 32'h300, (p < 8) ? 32'h200 : 32'h100);
		end
		wr(pstc_pkg::REG_CTRL, 32'h3);
		for (int p = 8; p < 13; p++) begin
			join_grp(5'(p), 3'h3);
			chk("large join", rv & 32'h300, (p < 12) ? 32'h200 : 32'h100);
		end
		// Group 7 holds one member, so only speed or duplex can refuse
		join_grp(5'd22, 3'h7);
		chk("last group", rv & 32'h300, 32'h200);
		join_grp(5'd20, 3'h7);
		chk("speed mix", rv & 32'h300, 32'h100);
		join_grp(5'd21, 3'h7);
		chk("half duplex", rv & 32'h300, 32'h100);
		join_grp(5'd0, 3'h7);
		chk("moved", {28'h0, o_mem[0], o_gid[2:0]}, 32'hf);
		wr(pstc_pkg::REG_PORT_CFG, 32'h1);
		chk("normal", {31'h0, o_mem[0]}, 32'h0);
		wr(pstc_pkg::REG_PORT_SEL, 32'h3);
		rd(pstc_pkg::REG_GROUP_STAT);
		chk("group attr", rv & 32'h7040, 32'h6040);
		$display("done trunk");
	endtask : t_trunk
	task automatic t_reboot;
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_mclk);
		chk("reboot trunk", {8'h0, o_mem}, 32'h0);
		rd(pstc_pkg::REG_PORT_CFG);
		chk("reboot cfg", rv & 32'h7f, 32'h1);
		rd(pstc_pkg::REG_PORT_STAT);
		chk("reboot state", rv & 32'h3b7, 32'h1);
		$display("done reboot");
	endtask : t_reboot

	initial begin
		{i_rstn, i_wr, i_rd, i_addr, i_wdata} = '0;
		want_up = '1;
		want_fdx = 24'hdf_ffff;
		want_speed = 48'ha9aa_aaaa_aaaa;
		{n_errors, total_checks, cycles} = '0;
		repeat (8) @(posedge i_mclk);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_mclk);
		t_boot();
		t_walk();
		t_link();
		t_cfg();
		t_trunk();
		t_reboot();
		print_verdict();
	end
endmodule : port_state_trunk_ctrl_tb
